// file: core/casd_pkg.sv
// Purpose: Shared constants and types for the CPU address space decoder.
// Assumes: 26-bit physical space, 32-bit operand addresses, 32-bit memory words.
// Notes: Addresses below are physical unless named as full 32-bit values.
package casd_pkg;

    // Address widths.
    localparam int ADDR_W = 32;
    localparam int PHYS_W = 26;
    localparam int PIO_OFS_W = 12;

    // Internal ROM region and its populated tops for the two variants.
    localparam logic [25:0] ROM_REGION_TOP = 26'h00FFFFF;
    localparam logic [25:0] ROM_LARGE_TOP = 26'h001FFFF;
    localparam logic [25:0] ROM_SMALL_TOP = 26'h000FFFF;

    // Internal RAM region, physical RAM window and peripheral area.
    localparam logic [25:0] RAM_REGION_BASE = 26'h3FF0000;
    localparam logic [25:0] RAM_PHYS_BASE = 26'h3FFD800;
    localparam logic [25:0] RAM_PHYS_TOP = 26'h3FFEFFF;
    localparam logic [25:0] PIO_BASE = 26'h3FFF000;

    // Program counter start and sequential fetch step.
    localparam logic [25:0] RESET_ENTRY = 26'h0000000;
    localparam logic [25:0] FETCH_STEP = 26'h0000004;

    // RAM size configuration register.
    localparam logic [31:0] RAMSZ_ADDR = 32'hFFFFF9F0;
    localparam logic [7:0] RAMSZ_RESET = 8'h00;
    localparam logic [7:0] RAMSZ_ENABLE = 8'h01;

    // Decoded target of an access.
    typedef enum logic [1:0] {
        REG_ROM = 2'b00,
        REG_RAM = 2'b01,
        REG_PIO = 2'b10,
        REG_NONE = 2'b11
    } casd_region_t;

    // Operand access size.
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } casd_size_t;

    // Operating mode taken from the two mode pins.
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_FLASH = 2'b01,
        MODE_BAD = 2'b10
    } casd_mode_t;

endpackage

// file: core/casd_dec_if.sv
// Purpose: Carries one address lookup between the top and a region decoder.
// Assumes: Lookup is purely combinational.
// Notes: One instance per lookup path, fetch and operand.
`timescale 1ns/1ps
interface casd_dec_if;
    logic [31:0] addr;
    logic is_fetch;
    logic ram_on;
    casd_pkg::casd_region_t region;

    // The top asks, the decoder answers.
    modport req (output addr, output is_fetch, output ram_on, input region);
    modport dec (input addr, input is_fetch, input ram_on, output region);
endinterface

// file: core/casd_region_dec.sv
// Purpose: Maps an address to ROM, RAM, peripheral area or a refused hole.
// Assumes: Fetch addresses have bits 31 to 26 at zero.
// Notes: Unpopulated parts of the ROM and RAM regions decode as refused.
`timescale 1ns/1ps
module casd_region_dec #(
    parameter bit ROM_LARGE = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    casd_dec_if.dec lk
);
    wire [25:0] phys = lk.addr[25:0];
    wire [25:0] rom_top = ROM_LARGE ? casd_pkg::ROM_LARGE_TOP : casd_pkg::ROM_SMALL_TOP;
    wire rom_pop = phys <= rom_top;
    wire ram_pop = (phys >= casd_pkg::RAM_PHYS_BASE) && (phys <= casd_pkg::RAM_PHYS_TOP);
    wire in_pio = phys >= casd_pkg::PIO_BASE;
    wire canon = lk.addr[31:26] == {6{lk.addr[25]}};

    // Bits 31 to 26 never pick a location; they only gate the peripheral image.
    // Fetches never reach the peripheral area, and data reaches it only via the top mirror.
    assign lk.region = rom_pop ? casd_pkg::REG_ROM :
        (ram_pop && lk.ram_on) ? casd_pkg::REG_RAM :
        (in_pio && !lk.is_fetch && canon) ? casd_pkg::REG_PIO :
        casd_pkg::REG_NONE;

    // A ROM hit always lies inside the populated part.
    property p_rom_pop;
        @(posedge mclk) disable iff (rst)
        lk.region == casd_pkg::REG_ROM |-> lk.addr[25:0] <= rom_top;
    endproperty
    a_rom_pop: assert property (p_rom_pop) else $error("ROM hit outside populated ROM.");

    // A peripheral hit is a data access through the sign-extended image.
    property p_pio_canon;
        @(posedge mclk) disable iff (rst)
        lk.region == casd_pkg::REG_PIO |-> !lk.is_fetch && lk.addr[31:26] == {6{lk.addr[25]}};
    endproperty
    a_pio_canon: assert property (p_pio_canon) else $error("Bad peripheral hit.");
endmodule // casd_region_dec

// file: core/casd_pio_split.sv
// Purpose: Turns one operand access into halfword peripheral cycles.
// Assumes: Peripheral answers read data in the same cycle as its strobe.
// Notes: Word accesses take two cycles on the peripheral port.
`timescale 1ns/1ps
module casd_pio_split (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [11:0] ofs,
    input wire logic word,
    input wire logic write,
    input wire logic [31:0] wdata,
    output logic pio_en,
    output logic pio_we,
    output logic [11:0] pio_addr,
    output logic [15:0] pio_wdata,
    input wire logic [15:0] pio_rdata,
    input wire logic pio_byte_reg,
    output logic done,
    output logic [31:0] rdata
);
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_LO = 2'b01,
        SP_HI = 2'b10
    } casd_split_t;

    casd_split_t state_ff, nxt_state;
    logic [11:0] addr_ff;
    logic word_ff, we_ff, done_ff;
    logic [15:0] hi_ff, cur_ff;
    logic [31:0] rdata_ff;

    // A byte-wide register sees only the low byte and returns nothing above it.
    wire [15:0] rd_half = pio_byte_reg ? {8'h00, pio_rdata[7:0]} : pio_rdata;
    assign pio_en = state_ff != SP_IDLE;
    assign pio_we = we_ff;
    assign pio_addr = addr_ff;
    assign pio_wdata = pio_byte_reg ? {8'h00, cur_ff[7:0]} : cur_ff;
    assign done = done_ff;
    assign rdata = rdata_ff;

    // Lower half first, then the upper half of the same word.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            SP_IDLE: if (start) nxt_state = SP_LO;
            SP_LO: nxt_state = word_ff ? SP_HI : SP_IDLE;
            SP_HI: nxt_state = SP_IDLE;
            default: nxt_state = SP_IDLE;
        endcase
    end

    // The two low address bits are dropped for words so both halves stay in one word.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= SP_IDLE;
            addr_ff <= 12'h000;
            word_ff <= 1'b0;
            we_ff <= 1'b0;
            cur_ff <= 16'h0000;
            hi_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == SP_IDLE && start) begin
                addr_ff <= word ? {ofs[11:2], 2'b00} : ofs;
                word_ff <= word;
                we_ff <= write;
                cur_ff <= wdata[15:0];
                hi_ff <= wdata[31:16];
            end else if (state_ff == SP_LO) begin
                addr_ff <= {addr_ff[11:2], 2'b10};
                cur_ff <= hi_ff;
            end
        end
    end

    // Read halves are gathered and a pulse marks the end of the access.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_ff <= 32'h00000000;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == SP_LO && !word_ff) || state_ff == SP_HI;
            if (state_ff == SP_LO) rdata_ff <= {16'h0000, rd_half};
            if (state_ff == SP_HI) rdata_ff[31:16] <= rd_half;
        end
    end

    // A word start gives a lower and then an upper halfword cycle.
    sequence s_two_halves;
        pio_en && pio_addr[1:0] == 2'b00 ##1 pio_en && pio_addr[1:0] == 2'b10;
    endsequence
    property p_word_split;
        @(posedge mclk) disable iff (rst)
        state_ff == SP_IDLE && start && word |=> s_two_halves ##1 !pio_en && done;
    endproperty
    a_word_split: assert property (p_word_split) else $error("Word not split in two.");

    property p_byte_write;
        @(posedge mclk) disable iff (rst)
        pio_en && pio_we && pio_byte_reg |-> pio_wdata[15:8] == 8'h00;
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("Upper byte written.");
endmodule // casd_pio_split

// file: core/casd_top.sv
// Purpose: CPU address space decoder with mode pins and RAM size register.
// Assumes: ROM and RAM read one cycle after their strobe; memories are dual ported.
// Notes: Fetch and operand paths are decoded independently each cycle.
// Function
// - Mode pins pick normal, flash or prohibited.
// - Normal mode: port-mode pins, fetch from entry.
// - Program counter keeps only 26 low bits.
// - Operand address carry beyond 32 bits dropped.
// - Data space is 64 mirrors of 64 MB; ROM and RAM appear in every mirror, the peripheral area only in the top one.
// - Bit 25 sign-extends to form data addresses.
// - No instruction fetch from peripheral area.
// - ROM region 1 MB, large variant 128 KB.
// - Small variant populates 64 KB only.
// - Physical RAM 6 KB, rest of region refused.
// - RAM size register: byte, write once.
// - Peripheral area 4 KB, program fetch refused.
// - Word peripheral access becomes two halfwords.
// - Byte register halfword: low byte only.
// - No prefetch from RAM top into peripherals.
`timescale 1ns/1ps
module casd_top #(
    parameter bit ROM_LARGE = 1'b1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic flash_mode_pin_a,
    input wire logic flash_mode_pin_b,
    output logic mode_normal,
    output logic mode_flash,
    output logic mode_prohibited,
    output logic bus_port_mode,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic fetch_sel_ram,
    output logic fetch_fault,
    input wire logic fetch_ready,
    input wire logic branch_valid,
    input wire logic [31:0] branch_disp,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [31:0] op_base,
    input wire logic [31:0] op_disp,
    input wire logic op_write,
    input wire logic [1:0] op_size,
    input wire logic [31:0] op_wdata,
    output logic op_done,
    output logic op_fault,
    output logic [31:0] op_rdata,
    output logic rom_en,
    output logic [25:0] rom_addr,
    input wire logic [31:0] rom_rdata,
    output logic ram_en,
    output logic ram_we,
    output logic [3:0] ram_be,
    output logic [25:0] ram_addr,
    output logic [31:0] ram_wdata,
    input wire logic [31:0] ram_rdata,
    output logic pio_en,
    output logic pio_we,
    output logic [11:0] pio_addr,
    output logic [15:0] pio_wdata,
    input wire logic [15:0] pio_rdata,
    input wire logic pio_byte_reg
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01,
        ST_RD = 2'b10,
        ST_PIO = 2'b11
    } casd_op_t;

    logic pin_a_s1_ff, pin_a_s2_ff, pin_b_s1_ff, pin_b_s2_ff;
    casd_pkg::casd_mode_t mode_ff, nxt_mode;
    logic [25:0] pc_ff, nxt_pc;
    casd_op_t state_ff, nxt_state;
    logic [31:0] ea_ff, wdata_ff, op_rdata_ff, nxt_rdata;
    logic [1:0] size_ff;
    logic we_ff, tgt_ram_ff, op_done_ff, op_fault_ff, nxt_done, nxt_fault;
    logic [7:0] ims_ff;
    logic ims_done_ff;
    logic split_start, split_done;
    logic [31:0] split_rdata;
    logic [3:0] be_lanes;
    logic [31:0] wdata_lanes;

    casd_dec_if fetch_lk ();
    casd_dec_if data_lk ();

    // Mode pins come from outside and pass two flops before decoding.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_a_s1_ff <= 1'b0;
            pin_a_s2_ff <= 1'b0;
            pin_b_s1_ff <= 1'b0;
            pin_b_s2_ff <= 1'b0;
        end else begin
            pin_a_s1_ff <= flash_mode_pin_a;
            pin_a_s2_ff <= pin_a_s1_ff;
            pin_b_s1_ff <= flash_mode_pin_b;
            pin_b_s2_ff <= pin_b_s1_ff;
        end
    end

    // Pins are expected to stay fixed, so a plain level decode suffices.
    assign nxt_mode = !pin_a_s2_ff ? casd_pkg::MODE_NORMAL :
        !pin_b_s2_ff ? casd_pkg::MODE_FLASH : casd_pkg::MODE_BAD;
    always_ff @(posedge mclk) begin
        if (rst) mode_ff <= casd_pkg::MODE_NORMAL;
        else mode_ff <= nxt_mode;
    end
    assign mode_normal = mode_ff == casd_pkg::MODE_NORMAL;
    assign mode_flash = mode_ff == casd_pkg::MODE_FLASH;
    assign mode_prohibited = mode_ff == casd_pkg::MODE_BAD;
    assign bus_port_mode = mode_normal;

    // RAM opens only after the size register holds the enabling value.
    wire ram_on = ims_ff == casd_pkg::RAMSZ_ENABLE;

    // Fetch lookup uses the zero-extended program counter.
    assign fetch_lk.addr = {6'h00, pc_ff};
    assign fetch_lk.is_fetch = 1'b1;
    assign fetch_lk.ram_on = ram_on;
    casd_region_dec #(.ROM_LARGE(ROM_LARGE)) u_fetch_dec (
        .mclk(mclk),
        .rst(rst),
        .lk(fetch_lk)
    );

    // A sequential step off the RAM top lands in the peripheral area and is never issued.
    wire fetch_hit = fetch_lk.region == casd_pkg::REG_ROM ||
        fetch_lk.region == casd_pkg::REG_RAM;
    assign fetch_valid = mode_normal && !branch_valid && fetch_hit;
    assign fetch_fault = mode_normal && !fetch_hit;
    assign fetch_sel_ram = fetch_lk.region == casd_pkg::REG_RAM;
    assign fetch_addr = {6'h00, pc_ff};

    // Branch sums keep only the low 26 bits, so carries out of bit 25 vanish.
    wire [31:0] br_sum = {6'h00, pc_ff} + branch_disp;
    wire [25:0] pc_inc = pc_ff + casd_pkg::FETCH_STEP;
    assign nxt_pc = branch_valid ? br_sum[25:0] :
        (fetch_valid && fetch_ready) ? pc_inc : pc_ff;
    always_ff @(posedge mclk) begin
        if (rst) pc_ff <= casd_pkg::RESET_ENTRY;
        else if (mode_normal) pc_ff <= nxt_pc;
    end

    // Operand addresses wrap at 32 bits.
    wire [31:0] ea_sum = op_base + op_disp;
    assign data_lk.addr = ea_sum;
    assign data_lk.is_fetch = 1'b0;
    assign data_lk.ram_on = ram_on;
    casd_region_dec #(.ROM_LARGE(ROM_LARGE)) u_data_dec (
        .mclk(mclk),
        .rst(rst),
        .lk(data_lk)
    );

    assign op_ready = state_ff == ST_IDLE;
    wire accept = op_valid && op_ready;
    wire is_ramsz = ea_sum == casd_pkg::RAMSZ_ADDR;
    wire d_none = data_lk.region == casd_pkg::REG_NONE;
    wire d_rom = data_lk.region == casd_pkg::REG_ROM;
    wire d_pio = data_lk.region == casd_pkg::REG_PIO;
    wire ims_wr = accept && d_pio && is_ramsz && op_write &&
        op_size == casd_pkg::SZ_BYTE && !ims_done_ff;
    assign split_start = accept && d_pio && !is_ramsz;

    // Memory read data is aligned to the addressed byte.
    wire [31:0] mem_word = tgt_ram_ff ? ram_rdata : rom_rdata;
    wire [31:0] mem_aligned = mem_word >> {ea_ff[1:0], 3'b000};

    // Refused targets and ROM writes finish at once and touch nothing.
    always_comb begin
        nxt_state = state_ff;
        nxt_done = 1'b0;
        nxt_fault = 1'b0;
        nxt_rdata = op_rdata_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (accept && d_none) begin
                    nxt_done = 1'b1;
                    nxt_fault = 1'b1;
                    nxt_rdata = 32'h00000000;
                end else if (accept && d_rom && op_write) begin
                    nxt_done = 1'b1;
                end else if (accept && d_pio && is_ramsz) begin
                    nxt_done = 1'b1;
                    nxt_rdata = 32'h00000000;
                end else if (split_start) begin
                    nxt_state = ST_PIO;
                end else if (accept) begin
                    nxt_state = ST_MEM;
                end
            end
            ST_MEM: nxt_state = ST_RD;
            ST_RD: begin
                nxt_state = ST_IDLE;
                nxt_done = 1'b1;
                nxt_rdata = mem_aligned;
            end
            ST_PIO: begin
                if (split_done) begin
                    nxt_state = ST_IDLE;
                    nxt_done = 1'b1;
                    nxt_rdata = split_rdata;
                end
            end
        endcase
    end

    // Accepted operand fields are held for the memory cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            ea_ff <= 32'h00000000;
            wdata_ff <= 32'h00000000;
            size_ff <= 2'h0;
            we_ff <= 1'b0;
            tgt_ram_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (accept) begin
                ea_ff <= ea_sum;
                wdata_ff <= op_wdata;
                size_ff <= op_size;
                we_ff <= op_write;
                tgt_ram_ff <= data_lk.region == casd_pkg::REG_RAM;
            end
        end
    end

    // Answer to the core.
    always_ff @(posedge mclk) begin
        if (rst) begin
            op_done_ff <= 1'b0;
            op_fault_ff <= 1'b0;
            op_rdata_ff <= 32'h00000000;
        end else begin
            op_done_ff <= nxt_done;
            op_fault_ff <= nxt_fault;
            op_rdata_ff <= nxt_rdata;
        end
    end
    assign op_done = op_done_ff;
    assign op_fault = op_fault_ff;
    assign op_rdata = op_rdata_ff;

    // The size register takes the first byte write after reset and then freezes.
    always_ff @(posedge mclk) begin
        if (rst) begin
            ims_ff <= casd_pkg::RAMSZ_RESET;
            ims_done_ff <= 1'b0;
        end else if (ims_wr) begin
            ims_ff <= op_wdata[7:0];
            ims_done_ff <= 1'b1;
        end
    end

    // Byte lanes and replicated write data for the 32-bit memories.
    always_comb begin
        be_lanes = 4'hF;
        wdata_lanes = wdata_ff;
        if (size_ff == casd_pkg::SZ_BYTE) begin
            be_lanes = 4'h1 << ea_ff[1:0];
            wdata_lanes = {4{wdata_ff[7:0]}};
        end else if (size_ff == casd_pkg::SZ_HALF) begin
            be_lanes = ea_ff[1] ? 4'hC : 4'h3;
            wdata_lanes = {2{wdata_ff[15:0]}};
        end
    end

    // Only the physical bits reach the memories, which makes every mirror alike.
    assign rom_en = state_ff == ST_MEM && !tgt_ram_ff;
    assign rom_addr = ea_ff[25:0];
    assign ram_en = state_ff == ST_MEM && tgt_ram_ff;
    assign ram_we = we_ff;
    assign ram_be = be_lanes;
    assign ram_addr = ea_ff[25:0];
    assign ram_wdata = wdata_lanes;

    casd_pio_split u_split (
        .mclk(mclk),
        .rst(rst),
        .start(split_start),
        .ofs(ea_sum[11:0]),
        .word(op_size == casd_pkg::SZ_WORD),
        .write(op_write),
        .wdata(op_wdata),
        .pio_en(pio_en),
        .pio_we(pio_we),
        .pio_addr(pio_addr),
        .pio_wdata(pio_wdata),
        .pio_rdata(pio_rdata),
        .pio_byte_reg(pio_byte_reg),
        .done(split_done),
        .rdata(split_rdata)
    );

    property p_mode_decode;
        @(posedge mclk) disable iff (rst)
        pin_a_s2_ff && !pin_b_s2_ff |=> mode_flash && !mode_normal;
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("Flash mode not decoded.");

    property p_reset_entry;
        @(posedge mclk) disable iff (rst)
        $fell(rst) |-> pc_ff == casd_pkg::RESET_ENTRY && bus_port_mode && mode_normal;
    endproperty
    a_reset_entry: assert property (p_reset_entry) else $error("Bad start after reset.");

    property p_branch_wrap;
        @(posedge mclk) disable iff (rst)
        branch_valid && mode_normal |=> pc_ff == $past(br_sum[25:0]) && fetch_addr[31:26] == 6'h00;
    endproperty
    a_branch_wrap: assert property (p_branch_wrap) else $error("Branch did not wrap.");

    property p_ea_wrap;
        @(posedge mclk) disable iff (rst)
        accept |=> ea_ff == $past(op_base + op_disp);
    endproperty
    a_ea_wrap: assert property (p_ea_wrap) else $error("Operand address wrong.");

    property p_fetch_fence;
        @(posedge mclk) disable iff (rst)
        fetch_valid |-> fetch_addr[25:0] < casd_pkg::PIO_BASE && !fetch_fault;
    endproperty
    a_fetch_fence: assert property (p_fetch_fence) else $error("Fetch in peripheral area.");

    property p_ram_window;
        @(posedge mclk) disable iff (rst)
        ram_en |-> ram_addr >= casd_pkg::RAM_PHYS_BASE && ram_addr <= casd_pkg::RAM_PHYS_TOP;
    endproperty
    a_ram_window: assert property (p_ram_window) else $error("RAM strobe off window.");

    property p_ims_once;
        @(posedge mclk) disable iff (rst)
        ims_done_ff && accept && is_ramsz |=> $stable(ims_ff);
    endproperty
    a_ims_once: assert property (p_ims_once) else $error("Size register rewritten.");

    sequence s_quiet_done;
        op_done && op_fault && !rom_en && !ram_en && !pio_en;
    endsequence
    property p_refused;
        @(posedge mclk) disable iff (rst)
        accept && d_none |=> s_quiet_done;
    endproperty
    a_refused: assert property (p_refused) else $error("Refused access had effect.");
endmodule // casd_top

// file: verif/casd_mem_model.sv
// Purpose: ROM, RAM and peripheral responder on the decoder's far side.
// Assumes: Memories answer one cycle after the strobe, peripherals at once.
// Notes: Read data encodes the address; idle data is scrambled.
`timescale 1ns/1ps
module casd_mem_model (
    input wire logic mclk,
    input wire logic rom_en,
    input wire logic [25:0] rom_addr,
    output logic [31:0] rom_rdata,
    input wire logic ram_en,
    input wire logic [25:0] ram_addr,
    output logic [31:0] ram_rdata,
    input wire logic pio_en,
    input wire logic [11:0] pio_addr,
    output logic [15:0] pio_rdata,
    output logic pio_byte_reg
);
    // Inverting between strobes keeps a late sample from passing by luck.
    always_ff @(posedge mclk) begin
        rom_rdata <= rom_en ? {6'h00, rom_addr} : ~rom_rdata;
        ram_rdata <= ram_en ? {ram_addr, 6'h15} : ~ram_rdata;
    end
    // Byte-wide registers sit in the upper half of the peripheral area.
    assign pio_rdata = pio_en ? {4'hA, pio_addr} : {4'h5, ~pio_addr};
    assign pio_byte_reg = pio_addr[11];
endmodule // casd_mem_model

// file: verif/casd_top_tb.sv
// Purpose: Self-checking bench for the address space decoder.
// Assumes: Bench plays the CPU core and drives on the falling edge.
// Notes: Pins change mid-run only to visit every mode.
`timescale 1ns/1ps
module casd_top_tb;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic flash_mode_pin_a = 1'h0, flash_mode_pin_b = 1'h0;
    logic fetch_ready = 1'h0, branch_valid = 1'h0, op_valid = 1'h0, op_write = 1'h0;
    logic [31:0] branch_disp = 32'h0, op_base = 32'h0, op_disp = 32'h0, op_wdata = 32'h0;
    logic [1:0] op_size = 2'h0;
    logic mode_normal, mode_flash, mode_prohibited, bus_port_mode, fetch_valid;
    logic fetch_sel_ram, fetch_fault, op_ready, op_done, op_fault, rom_en, ram_en;
    logic ram_we, pio_en, pio_we, pio_byte_reg;
    logic [31:0] fetch_addr, op_rdata, rom_rdata, ram_wdata, ram_rdata;
    logic [25:0] rom_addr, ram_addr;
    logic [3:0] ram_be;
    logic [11:0] pio_addr;
    logic [15:0] pio_wdata, pio_rdata;
    int miscompares = 0, num_checks = 0, cycles = 0;
    logic [3:0] exp_be = 4'h0;
    logic [31:0] exp_wd = 32'h0;
    logic [15:0] exp_pw = 16'h0;

    always #2 mclk = ~mclk;

    casd_top #(.ROM_LARGE(1'h1)) i_casd_top (.mclk, .rst, .flash_mode_pin_a,
        .flash_mode_pin_b, .mode_normal, .mode_flash, .mode_prohibited, .bus_port_mode,
        .fetch_valid, .fetch_addr, .fetch_sel_ram, .fetch_fault, .fetch_ready,
        .branch_valid, .branch_disp, .op_valid, .op_ready, .op_base, .op_disp, .op_write,
        .op_size, .op_wdata, .op_done, .op_fault, .op_rdata, .rom_en, .rom_addr,
        .rom_rdata, .ram_en, .ram_we, .ram_be, .ram_addr, .ram_wdata, .ram_rdata, .pio_en,
        .pio_we, .pio_addr, .pio_wdata, .pio_rdata, .pio_byte_reg);
    casd_mem_model i_casd_mem_model (.mclk, .rom_en, .rom_addr, .rom_rdata, .ram_en,
        .ram_addr, .ram_rdata, .pio_en, .pio_addr, .pio_rdata, .pio_byte_reg);

    // Flags are widened so one compare serves flags and data words alike.
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Write strobes are checked while they stand, against what the scenario expects.
    always @(negedge mclk) begin
        if (ram_en === 1'h1 && ram_we === 1'h1) begin
            chk("ram_be", 32'(ram_be), 32'(exp_be));
            chk("ram_wdata", ram_wdata, exp_wd);
        end
        if (pio_en === 1'h1 && pio_we === 1'h1) chk("pio_wdata", 32'(pio_wdata), 32'(exp_pw));
    end

    // A hung handshake would otherwise stall the run forever.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // One operand access; the request is taken at the first rising edge since idle.
    task automatic op(input logic [31:0] b, input logic [31:0] d, input logic w,
        input logic [1:0] sz, input logic [31:0] wd, input logic ef, input logic [31:0] er);
        int n;
        op_base = b;
        op_disp = d;
        op_write = w;
        op_size = sz;
        op_wdata = wd;
        op_valid = 1'h1;
        @(negedge mclk);
        op_valid = 1'h0;
        n = 0;
        while (op_done !== 1'h1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        chk("op_done", 32'(op_done), 32'h1);
        chk("op_fault", 32'(op_fault), 32'(ef));
        if (!ef && !w) chk("op_rdata", op_rdata, er);
        @(negedge mclk);
    endtask

    initial begin
        repeat (12) @(negedge mclk);
        rst = 1'h0;
        @(negedge mclk);
        chk("mode_normal", 32'(mode_normal), 32'h1);
        chk("bus_port_mode", 32'(bus_port_mode), 32'h1);
        chk("fetch_addr", fetch_addr, 32'h0);
        chk("fetch_valid", 32'(fetch_valid), 32'h1);
        $display("test reset ended");
        // RAM is refused until 01H lands; the second write must not undo it.
        op(32'hFFFFD800, 32'h0, 1'h0, 2'h2, 32'h0, 1'h1, 32'h0);
        op(casd_pkg::RAMSZ_ADDR, 32'h0, 1'h1, 2'h0, 32'h01, 1'h0, 32'h0);
        op(casd_pkg::RAMSZ_ADDR, 32'h0, 1'h1, 2'h0, 32'h00, 1'h0, 32'h0);
        op(32'hFFFFE000, 32'hFFFFF800, 1'h0, 2'h2, 32'h0, 1'h0, {26'h3FFD800, 6'h15});
        op(32'hFFFF0000, 32'h0, 1'h0, 2'h2, 32'h0, 1'h1, 32'h0);
        $display("test ram ended");
        op(32'h0001FFF8, 32'h4, 1'h0, 2'h2, 32'h0, 1'h0, 32'h0001FFFC);
        op(32'h04000000, 32'h4, 1'h0, 2'h2, 32'h0, 1'h0, 32'h4);
        op(32'h00020000, 32'h0, 1'h0, 2'h2, 32'h0, 1'h1, 32'h0);
        op(32'hFFFFF104, 32'h2, 1'h0, 2'h2, 32'h0, 1'h0, 32'hA106A104);
        op(32'hFFFFF800, 32'h4, 1'h0, 2'h1, 32'h0, 1'h0, 32'h00000004);
        exp_pw = 16'h0034;
        op(32'hFFFFF800, 32'h0, 1'h1, 2'h1, 32'h1234, 1'h0, 32'h0);
        exp_be = 4'h2;
        exp_wd = 32'h5A5A5A5A;
        op(32'hFFFFD800, 32'h1, 1'h1, 2'h0, 32'h5A, 1'h0, 32'h0);
        op(32'h03FFF104, 32'h0, 1'h0, 2'h1, 32'h0, 1'h1, 32'h0);
        $display("test operand ended");
        // Fetch walks off the RAM top into the peripheral area and is stopped.
        branch_disp = 32'h03FFEFFC;
        branch_valid = 1'h1;
        @(negedge mclk);
        branch_valid = 1'h0;
        fetch_ready = 1'h1;
        chk("fetch_sel_ram", 32'(fetch_sel_ram), 32'h1);
        @(negedge mclk);
        fetch_ready = 1'h0;
        chk("fetch_valid", 32'(fetch_valid), 32'h0);
        chk("fetch_fault", 32'(fetch_fault), 32'h1);
        branch_disp = 32'h00001000;
        branch_valid = 1'h1;
        @(negedge mclk);
        branch_valid = 1'h0;
        chk("fetch_addr", fetch_addr, 32'h0);
        $display("test fetch ended");
        // Pins only change while reset is held, so they stay fixed during operation.
        rst = 1'h1;
        flash_mode_pin_a = 1'h1;
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        repeat (4) @(negedge mclk);
        chk("mode_flash", 32'(mode_flash), 32'h1);
        chk("fetch_valid", 32'(fetch_valid), 32'h0);
        rst = 1'h1;
        flash_mode_pin_b = 1'h1;
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        repeat (4) @(negedge mclk);
        chk("mode_prohibited", 32'(mode_prohibited), 32'h1);
        $display("test mode ended");
        tally_and_finish();
    end
endmodule // casd_top_tb
